/* File: include/upevr_pkg.sv */
package upevr_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam logic [5:0] RISE_WR_IDX = 6'h0D;
  localparam logic [5:0] RISE_SET_IDX = 6'h0E;
  localparam logic [5:0] RISE_CLR_IDX = 6'h0F;
  localparam logic [5:0] FALL_WR_IDX = 6'h10;
  localparam logic [5:0] FALL_SET_IDX = 6'h11;
  localparam logic [5:0] FALL_CLR_IDX = 6'h12;
  localparam logic [5:0] LEVEL_IDX = 6'h13;
  localparam logic [5:0] LATCH_IDX = 6'h14;
  localparam logic [5:0] DEBUG_IDX = 6'h15;
  localparam logic [5:0] SCR_WR_IDX = 6'h16;
  localparam logic [5:0] SCR_SET_IDX = 6'h17;
  localparam logic [5:0] SCR_CLR_IDX = 6'h18;
  localparam int unsigned SRC_W = 5;
  localparam int unsigned BIT_DISC = 0;
  localparam int unsigned BIT_VBUS = 1;
  localparam int unsigned BIT_SESSV = 2;
  localparam int unsigned BIT_SESSE = 3;
  localparam int unsigned BIT_ID = 4;
  localparam logic [4:0] EDGE_EN_RST = 5'h1F;
  localparam logic [7:0] SCRATCH_RST = 8'h00;
  localparam logic [4:0] LATCH_RST = 5'h00;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  typedef struct packed {
    logic id_pin_grounded;
    logic session_end_level;
    logic session_valid_level;
    logic vbus_valid_level;
    logic host_disconnect_level;
  } upevr_src_t;

  typedef struct packed {
    logic       read;
    logic       write;
    logic [7:0] address;
    logic [31:0] writedata;
  } upevr_req_t;
endpackage

/* File: verilog/upevr_top.sv */
`timescale 1ns/10ps
`default_nettype none
module upevr_top
  import upevr_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               resetn,
  input  wire logic               clk_en,
  input  wire upevr_pkg::upevr_req_t avs_req,
  output logic                    avs_waitrequest,
  output logic [31:0]             avs_readdata,
  output logic                    avs_readdatavalid,
  input  wire upevr_pkg::upevr_src_t src_pins,
  input  wire logic [1:0]         line_state_pins,
  input  wire logic               host_mode
);
  import upevr_pkg::*;

  upevr_src_t  src_s1_r;
  upevr_src_t  src_s2_r;
  upevr_src_t  src_prev_r;
  logic [1:0]  line_s1_r;
  logic [1:0]  line_s2_r;
  logic        host_s1_r;
  logic        host_s2_r;
  logic        prev_valid_r;
  logic [4:0]  rise_en_r;
  logic [4:0]  fall_en_r;
  logic [4:0]  latch_r;
  logic [7:0]  scratch_r;
  logic        ack_r;
  logic [5:0]  idx;
  logic        req_act;
  logic        do_wr;
  logic        do_rd;
  logic [4:0]  cur;
  logic [4:0]  prv;
  logic [4:0]  ev;
  logic [4:0]  host_mask;
  logic [4:0]  level_view;
  logic [7:0]  rd_mux;
  logic [7:0]  rise_nxt;
  logic [7:0]  fall_nxt;

  function automatic logic [7:0] wsc(input logic [7:0] old, input logic [7:0] d,
                                     input logic [1:0] op);
    case (op)
      2'h0: wsc = d;
      2'h1: wsc = old | d;
      2'h2: wsc = old & ~d;
      default: wsc = old;
    endcase
  endfunction

  // Byte address is four times the printed index; low address bits ignored
  assign idx     = avs_req.address[7:2];
  assign req_act = clk_en && (avs_req.read || avs_req.write) && !ack_r;
  assign do_wr   = req_act && avs_req.write;
  assign do_rd   = req_act && avs_req.read;

  // Full byte result first; the enable registers keep only their five live bits
  assign rise_nxt = wsc({3'h0, rise_en_r}, avs_req.writedata[7:0], 2'(idx - RISE_WR_IDX));
  assign fall_nxt = wsc({3'h0, fall_en_r}, avs_req.writedata[7:0], 2'(idx - FALL_WR_IDX));

  // Two-stage synchronisers on asynchronous comparator and line inputs
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      src_s1_r  <= '0;
      src_s2_r  <= '0;
      line_s1_r <= 2'h0;
      line_s2_r <= 2'h0;
      host_s1_r <= 1'b0;
      host_s2_r <= 1'b0;
    end
    else if (clk_en)
    begin
      src_s1_r  <= src_pins;
      src_s2_r  <= src_s1_r;
      line_s1_r <= line_state_pins;
      line_s2_r <= line_s1_r;
      host_s1_r <= host_mode;
      host_s2_r <= host_s1_r;
    end
  end

  // First cycle after reset seeds the history with the synchronisers' reset zero; a pin high from reset shows as a rise edge
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      src_prev_r   <= '0;
      prev_valid_r <= 1'b0;
    end
    else if (clk_en)
    begin
      src_prev_r   <= src_s2_r;
      prev_valid_r <= 1'b1;
    end
  end

  assign cur       = src_s2_r;
  assign prv       = src_prev_r;
  assign host_mask = {4'hF, host_s2_r};
  assign ev = prev_valid_r ? (host_mask & ((rise_en_r & cur & ~prv) |
                                           (fall_en_r & ~cur & prv))) : 5'h00;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      rise_en_r <= EDGE_EN_RST;
    else if (do_wr && idx >= RISE_WR_IDX && idx <= RISE_CLR_IDX)
      rise_en_r <= rise_nxt[4:0];
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      fall_en_r <= EDGE_EN_RST;
    else if (do_wr && idx >= FALL_WR_IDX && idx <= FALL_CLR_IDX)
      fall_en_r <= fall_nxt[4:0];
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      scratch_r <= SCRATCH_RST;
    else if (do_wr && idx >= SCR_WR_IDX && idx <= SCR_CLR_IDX)
      scratch_r <= wsc(scratch_r, avs_req.writedata[7:0],
                       2'(idx - SCR_WR_IDX));
  end

  // New events are ORed after the read clear so none is lost
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      latch_r <= LATCH_RST;
    else if (clk_en)
    begin
      if (do_rd && idx == LATCH_IDX)
        latch_r <= ev;
      else
        latch_r <= latch_r | ev;
    end
  end

  // Masking keeps a both-edge VBUS or session end source from showing a stale level
  always_comb
  begin
    level_view = cur;
    level_view[BIT_VBUS]  = cur[BIT_VBUS]  & ~(rise_en_r[BIT_VBUS]  & fall_en_r[BIT_VBUS]);
    level_view[BIT_SESSE] = cur[BIT_SESSE] & ~(rise_en_r[BIT_SESSE] & fall_en_r[BIT_SESSE]);
  end

  always_comb
  begin
    rd_mux = UNMAPPED_DATA;
    if (idx >= RISE_WR_IDX && idx <= RISE_CLR_IDX)
      rd_mux = {3'h0, rise_en_r};
    else if (idx >= FALL_WR_IDX && idx <= FALL_CLR_IDX)
      rd_mux = {3'h0, fall_en_r};
    else if (idx == LEVEL_IDX)
      rd_mux = {3'h0, level_view};
    else if (idx == LATCH_IDX)
      rd_mux = {3'h0, latch_r};
    else if (idx == DEBUG_IDX)
      rd_mux = {6'h00, line_s2_r};
    else if (idx >= SCR_WR_IDX && idx <= SCR_CLR_IDX)
      rd_mux = scratch_r;
  end

  // One wait state: waitrequest drops for exactly one cycle per request
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      ack_r             <= 1'b0;
      avs_waitrequest   <= 1'b1;
      avs_readdata      <= 32'h0000_0000;
      avs_readdatavalid <= 1'b0;
    end
    else if (clk_en)
    begin
      ack_r             <= req_act;
      avs_waitrequest   <= !req_act;
      avs_readdatavalid <= do_rd;
      if (do_rd)
        avs_readdata <= {24'h00_0000, rd_mux};
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // A read of the latch, and an edge that may arrive in the same cycle
  sequence latch_read_s;
    clk_en && do_rd && idx == LATCH_IDX;
  endsequence

  sequence any_event_s;
    ev != 5'h00;
  endsequence

  latch_clear_a: assert property (
      latch_read_s
      |=> latch_r == $past(ev))
    else $error("latch not cleared by read");

  event_keep_a: assert property (
      (latch_read_s and any_event_s)
      |=> (latch_r & $past(ev)) != 5'h00)
    else $error("event lost on latch read");

  latch_set_a: assert property (
      clk_en && ev[BIT_ID]
      |=> latch_r[BIT_ID])
    else $error("id event not latched");

  host_only_a: assert property (
      !host_s2_r
      |-> !ev[BIT_DISC])
    else $error("disconnect event outside host");

  vbus_mask_a: assert property (
      rise_en_r[BIT_VBUS] && fall_en_r[BIT_VBUS]
      |-> !level_view[BIT_VBUS])
    else $error("vbus status not masked");

  sesse_mask_a: assert property (
      rise_en_r[BIT_SESSE] && fall_en_r[BIT_SESSE]
      |-> !level_view[BIT_SESSE])
    else $error("session end status not masked");

  sessv_live_a: assert property (
      level_view[BIT_SESSV] == cur[BIT_SESSV])
    else $error("session valid not live");

  rise_set_a: assert property (
      do_wr && idx == RISE_SET_IDX
      |=> rise_en_r == ($past(rise_en_r) | $past(avs_req.writedata[4:0])))
    else $error("rise set failed");

  fall_clr_a: assert property (
      do_wr && idx == FALL_CLR_IDX
      |=> fall_en_r == ($past(fall_en_r) & ~$past(avs_req.writedata[4:0])))
    else $error("fall clear failed");

  scratch_wr_a: assert property (
      do_wr && idx == SCR_WR_IDX
      |=> scratch_r == $past(avs_req.writedata[7:0]))
    else $error("scratch write failed");

  ack_once_a: assert property (
      req_act
      |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest not single cycle");

  rise_wr_a: assert property (
      do_wr && idx == RISE_WR_IDX
      |=> rise_en_r == $past(avs_req.writedata[4:0]))
    else $error("rise load failed");

  rise_clr_a: assert property (
      do_wr && idx == RISE_CLR_IDX
      |=> rise_en_r == ($past(rise_en_r) & ~$past(avs_req.writedata[4:0])))
    else $error("rise clear failed");

  fall_wr_a: assert property (
      do_wr && idx == FALL_WR_IDX
      |=> fall_en_r == $past(avs_req.writedata[4:0]))
    else $error("fall load failed");

  fall_set_a: assert property (
      do_wr && idx == FALL_SET_IDX
      |=> fall_en_r == ($past(fall_en_r) | $past(avs_req.writedata[4:0])))
    else $error("fall set failed");

  scratch_set_a: assert property (
      do_wr && idx == SCR_SET_IDX
      |=> scratch_r == ($past(scratch_r) | $past(avs_req.writedata[7:0])))
    else $error("scratch set failed");

  scratch_clr_a: assert property (
      do_wr && idx == SCR_CLR_IDX
      |=> scratch_r == ($past(scratch_r) & ~$past(avs_req.writedata[7:0])))
    else $error("scratch clear failed");

  scratch_keep_a: assert property (
      clk_en && !(do_wr && idx >= SCR_WR_IDX && idx <= SCR_CLR_IDX)
      |=> scratch_r == $past(scratch_r))
    else $error("scratch changed without write");

  disc_rise_a: assert property (
      prev_valid_r && host_s2_r && rise_en_r[BIT_DISC] && cur[BIT_DISC] && !prv[BIT_DISC]
      |-> ev[BIT_DISC])
    else $error("disconnect rise missed");

  vbus_rise_a: assert property (
      prev_valid_r && rise_en_r[BIT_VBUS] && cur[BIT_VBUS] && !prv[BIT_VBUS]
      |-> ev[BIT_VBUS])
    else $error("vbus rise missed");

  sessv_fall_a: assert property (
      prev_valid_r && fall_en_r[BIT_SESSV] && !cur[BIT_SESSV] && prv[BIT_SESSV]
      |-> ev[BIT_SESSV])
    else $error("session valid fall missed");

  disc_fall_a: assert property (
      prev_valid_r && host_s2_r && fall_en_r[BIT_DISC] && !cur[BIT_DISC] && prv[BIT_DISC]
      |-> ev[BIT_DISC])
    else $error("disconnect fall missed");

  level_read_a: assert property (
      do_rd && idx == LEVEL_IDX
      |=> avs_readdata[4:0] == $past(level_view))
    else $error("status read not live");

  live_bits_a: assert property (
      level_view[BIT_ID] == cur[BIT_ID] && level_view[BIT_DISC] == cur[BIT_DISC])
    else $error("id or disconnect status not live");

  latch_sticky_a: assert property (
      clk_en && !(do_rd && idx == LATCH_IDX)
      |=> (latch_r & $past(latch_r)) == $past(latch_r))
    else $error("latched event dropped");

  latch_disc_a: assert property (
      clk_en && ev[BIT_DISC]
      |=> latch_r[BIT_DISC])
    else $error("disconnect event not latched");

  latch_ro_a: assert property (
      do_wr && idx == LATCH_IDX
      |=> latch_r == ($past(latch_r) | $past(ev)))
    else $error("latch changed by write");

  upper_zero_a: assert property (
      do_rd && idx < SCR_WR_IDX
      |=> avs_readdata[7:5] == 3'h0)
    else $error("reserved bits not zero");

  debug_view_a: assert property (
      do_rd && idx == DEBUG_IDX
      |=> avs_readdata[7:0] == {6'h00, $past(line_s2_r)})
    else $error("debug read wrong");

  unmapped_rd_a: assert property (
      do_rd && idx > SCR_CLR_IDX
      |=> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  rdvalid_a: assert property (
      do_rd
      |=> avs_readdatavalid)
    else $error("read data valid missing");

  // Clock enable low must leave the latch and scratch registers untouched
  freeze_a: assert property (
      !clk_en
      |=> latch_r == $past(latch_r) && scratch_r == $past(scratch_r))
    else $error("state changed while frozen");
endmodule
`default_nettype wire

/* File: tb/upevr_link_model.sv */
`timescale 1ns/10ps
`default_nettype none
module upevr_link_model
(
  input  wire logic            mclk,
  input  wire logic            waitreq,
  input  wire logic [31:0]     rdata,
  output var upevr_pkg::upevr_req_t req
);
  import upevr_pkg::*;
  initial req = '0;
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd, output logic ok);
    int n;
    n = 0;
    @(posedge mclk);
    req <= '{read: !wr, write: wr, address: {idx, 2'b00}, writedata: {24'h0, wd}};
    // Held until waitrequest is sampled low; data is taken at that same edge
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (waitreq !== 1'b0 && n < 50);
    rd = rdata[7:0];
    ok = (n < 50);
    req <= '0;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_usb_phy_event_regs.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_usb_phy_event_regs;
  import upevr_pkg::*;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  upevr_req_t  req;
  logic        waitreq;
  logic [31:0] rdata;
  upevr_src_t  src = '0;
  logic [1:0]  lines = 2'b00;
  logic        host = 1'b0;
  int          n_fail = 0;
  int          n_checks = 0;
  logic [7:0]  rv;
  logic        ok;
  always #12.5 mclk = ~mclk;
  upevr_top upevr_top_inst (.mclk(mclk), .resetn(resetn), .clk_en(1'b1), .avs_req(req),
    .avs_waitrequest(waitreq), .avs_readdata(rdata), .avs_readdatavalid(),
    .src_pins(src), .line_state_pins(lines), .host_mode(host));
  upevr_link_model upevr_link_model_inst (.mclk(mclk), .waitreq(waitreq), .rdata(rdata),
    .req(req));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic acc(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
    upevr_link_model_inst.xfer(wr, idx, wd, rv, ok);
    if (ok !== 1'b1)
    begin
      n_fail++;
      complete_run();
    end
  endtask
  task automatic rc(input string what, input logic [5:0] idx, input logic [7:0] exp);
    acc(1'b0, idx, 8'h00);
    chk(what, rv, exp);
  endtask
  // Sync chain plus edge history needs three cycles; six leaves margin
  task automatic settle();
    repeat (6) @(posedge mclk);
  endtask
  task automatic t_reset();
    rc("rise_rst", RISE_WR_IDX, 8'h1F);
    rc("fall_rst", FALL_WR_IDX, 8'h1F);
    rc("scr_rst", SCR_WR_IDX, SCRATCH_RST);
    rc("latch_rst", LATCH_IDX, 8'h00);
    rc("unmapped", 6'h19, UNMAPPED_DATA);
  endtask
  task automatic t_triples();
    logic [5:0] base [3] = '{RISE_WR_IDX, FALL_WR_IDX, SCR_WR_IDX};
    logic [7:0] msk [3] = '{8'h1F, 8'h1F, 8'hFF};
    for (int i = 0; i < 3; i++)
    begin
      acc(1'b1, base[i], 8'hA5);
      rc("load", base[i] + 6'd2, 8'hA5 & msk[i]);
      acc(1'b1, base[i] + 6'd1, 8'h5A);
      rc("set", base[i], msk[i]);
      acc(1'b1, base[i] + 6'd2, 8'h3C);
      rc("clear", base[i] + 6'd1, 8'hC3 & msk[i]);
      acc(1'b1, base[i], 8'h1F);
    end
  endtask
  task automatic t_levels();
    @(posedge mclk);
    host <= 1'b1;
    lines <= 2'b10;
    src <= 5'h1F;
    settle();
    rc("latch_rise", LATCH_IDX, 8'h1F);
    rc("latch_clr", LATCH_IDX, 8'h00);
    rc("lvl_masked", LEVEL_IDX, 8'h15);
    acc(1'b1, RISE_CLR_IDX, 8'h0A);
    rc("lvl_live", LEVEL_IDX, 8'h1F);
    rc("debug", DEBUG_IDX, 8'h02);
    acc(1'b1, LATCH_IDX, 8'hFF);
    rc("latch_ro", LATCH_IDX, 8'h00);
  endtask
  task automatic t_fall();
    acc(1'b1, FALL_WR_IDX, 8'h04);
    @(posedge mclk);
    host <= 1'b0;
    src <= 5'h00;
    settle();
    rc("latch_fall", LATCH_IDX, 8'h04);
    @(posedge mclk);
    src <= 5'h01;
    settle();
    rc("latch_host", LATCH_IDX, 8'h00);
  endtask
  initial
  begin
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    t_reset();
    t_triples();
    t_levels();
    t_fall();
    complete_run();
  end
endmodule
`default_nettype wire
